// *** hw/bsrot_regs.sv ***
// setpoint register bank of a dual-channel buck led controller
// assumes the serial frame decoder drives the register port on CORE_CLK
//
// What this block does
// - channel 2 peak threshold: 8-bit rw in bits 7-0, reset 80h, bit 8 zero
// - peak threshold may change anytime; analog code follows within about 1 us
// - peak code is sense voltage in millivolts, code divided by 1000 volts
// - each channel has an 8-bit rw off-time code, reset 80h, bit 8 zero
// - off-time equals code over 2.136e6 times the channel led voltage
// - each channel has an 8-bit rw maximum off-time code, reset 80h
// - maximum off-time is code times 50 clocks, 250 ns rather than 251 ns, independent of output voltage
// - maximum off-time timer runs beside the regular off timer
// - below about 2 V led voltage the maximum off timer ends the interval
// - after power-on reset wait one maximum off-time before first cycle
// - die temperature register: read-only, reset 0, latest adc conversion
// - temperature in celsius is 2.439 times code minus 293.5
// - thermal warning latches when temperature code exceeds warning limit, reset 80h
`timescale 1ns/1ps
`default_nettype none
`include "bsrot_consts.svh"
module bsrot_regs
    import bsrot_pkg::*;
#(
    parameter int MAXOFF_LSB_CYC = `BSROT_MAXOFF_LSB_CYC
)(
    // clock, reset, enable
    input  wire logic                       CORE_CLK,
    input  wire logic                       RST_B,
    input  wire logic                       CLK_EN,
    // register port from the serial frame decoder
    input  wire logic [`BSROT_ADDR_W-1:0]   REG_ADDR,
    input  wire logic [8:0]                 REG_WDATA,
    input  wire logic                       REG_WR,
    input  wire logic                       REG_RD,
    output var  logic [8:0]                 REG_RDATA,
    output var  logic                       REG_RVALID,
    // adc results, same clock
    input  wire bsrot_code_type             TEMP_ADC_CODE,
    input  wire logic                       TEMP_ADC_VALID,
    input  wire bsrot_code_type             VLED1_ADC_CODE,
    input  wire logic                       VLED1_ADC_PWM,
    input  wire logic                       VLED1_ADC_VALID,
    // status read clear of the thermal warning
    input  wire logic                       WARN_CLR,
    // converter off intervals, bit 0 channel 1, bit 1 channel 2
    input  wire logic [1:0]                 CH_OFF_START,
    input  wire logic [1:0]                 CH_TOFF_DONE,
    input  wire logic [1:0]                 CH_LOW_VLED,
    output var  logic [1:0]                 CH_OFF_END,
    output var  logic [1:0]                 CH_MAXOFF_HIT,
    output var  logic [1:0]                 CH_START_OK,
    // dac codes
    output var  bsrot_code_type             CH2_PEAK_CODE,
    output var  bsrot_code_type             CH1_OFF_CODE,
    output var  bsrot_code_type             CH2_OFF_CODE,
    output var  bsrot_code_type             CH1_MAXOFF_CODE,
    output var  bsrot_code_type             CH2_MAXOFF_CODE,
    // status
    output var  logic                       THERMAL_WARNING
);
    localparam int DAC_CYC = `BSROT_DAC_UPDATE_CYC;

    // ------------------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------------------
    // setpoints are the registers whose bit 8 is reserved and writes land
    function automatic logic is_setpoint(input logic [`BSROT_ADDR_W-1:0] a);
        is_setpoint = (a == `BSROT_OFS_WARN_LIMIT) || (a == `BSROT_OFS_CH2_PEAK)
                   || (a == `BSROT_OFS_CH1_OFF)    || (a == `BSROT_OFS_CH2_OFF)
                   || (a == `BSROT_OFS_CH1_MAXOFF) || (a == `BSROT_OFS_CH2_MAXOFF);
    endfunction : is_setpoint

    // ------------------------------------------------------------------------
    // setpoint storage
    // ------------------------------------------------------------------------
    bsrot_code_type warn_limit_q;
    bsrot_code_type peak2_q;
    bsrot_code_type off_q    [2];
    bsrot_code_type maxoff_q [2];
    logic           wr_en;

    assign wr_en = CLK_EN && REG_WR && is_setpoint(REG_ADDR);

    // only the 8-bit field is stored, so bit 8 of a write falls away
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            warn_limit_q <= `BSROT_RST_WARN_LIMIT;
            peak2_q      <= `BSROT_RST_SETPOINT;
            off_q[0]     <= `BSROT_RST_SETPOINT;
            off_q[1]     <= `BSROT_RST_SETPOINT;
            maxoff_q[0]  <= `BSROT_RST_SETPOINT;
            maxoff_q[1]  <= `BSROT_RST_SETPOINT;
        end else if (wr_en) begin
            unique case (REG_ADDR)
                `BSROT_OFS_WARN_LIMIT: warn_limit_q <= REG_WDATA[`BSROT_CODE_MSB:0];
                `BSROT_OFS_CH2_PEAK:   peak2_q      <= REG_WDATA[`BSROT_CODE_MSB:0];
                `BSROT_OFS_CH1_OFF:    off_q[0]     <= REG_WDATA[`BSROT_CODE_MSB:0];
                `BSROT_OFS_CH2_OFF:    off_q[1]     <= REG_WDATA[`BSROT_CODE_MSB:0];
                `BSROT_OFS_CH1_MAXOFF: maxoff_q[0]  <= REG_WDATA[`BSROT_CODE_MSB:0];
                `BSROT_OFS_CH2_MAXOFF: maxoff_q[1]  <= REG_WDATA[`BSROT_CODE_MSB:0];
                default:               ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // readings captured from the adc
    // ------------------------------------------------------------------------
    bsrot_code_type temp_q;
    bsrot_code_type vled1_q;
    logic           vled1_pwm_q;

    // raw code kept as read; scaling to celsius is left to host software
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            temp_q <= `BSROT_RST_READING;
        end else if (CLK_EN && TEMP_ADC_VALID) begin
            temp_q <= TEMP_ADC_CODE;
        end
    end

    // pwm state travels with the sample it belongs to
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            vled1_q     <= `BSROT_RST_READING;
            vled1_pwm_q <= 1'b0;
        end else if (CLK_EN && VLED1_ADC_VALID) begin
            vled1_q     <= VLED1_ADC_CODE;
            vled1_pwm_q <= VLED1_ADC_PWM;
        end
    end

    // ------------------------------------------------------------------------
    // register read: answer one cycle after the strobe, unmapped reads zero
    // ------------------------------------------------------------------------
    logic [8:0]               rd_d;
    logic [`BSROT_ADDR_W-1:0] rd_addr_q;

    always_comb begin
        rd_d = 9'h000;
        unique case (REG_ADDR)
            `BSROT_OFS_WARN_LIMIT: rd_d = {1'b0, warn_limit_q};
            `BSROT_OFS_CH2_PEAK:   rd_d = {1'b0, peak2_q};
            `BSROT_OFS_CH1_OFF:    rd_d = {1'b0, off_q[0]};
            `BSROT_OFS_CH2_OFF:    rd_d = {1'b0, off_q[1]};
            `BSROT_OFS_CH1_MAXOFF: rd_d = {1'b0, maxoff_q[0]};
            `BSROT_OFS_CH2_MAXOFF: rd_d = {1'b0, maxoff_q[1]};
            `BSROT_OFS_DIE_TEMP:   rd_d = {1'b0, temp_q};
            `BSROT_OFS_CH1_LATEST: rd_d = {vled1_pwm_q, vled1_q};
            default:               rd_d = 9'h000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA  <= 9'h000;
            REG_RVALID <= 1'b0;
            rd_addr_q  <= '0;
        end else if (CLK_EN) begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rd_d;
                rd_addr_q <= REG_ADDR;
            end
        end
    end

    // ------------------------------------------------------------------------
    // dac codes: one flop after the register, far inside the 1 us budget
    // ------------------------------------------------------------------------
    // the analog side turns these into 1 mV per count (peak) and the V*s
    // product with the led voltage (off time); digital only carries codes
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CH2_PEAK_CODE   <= `BSROT_RST_SETPOINT;
            CH1_OFF_CODE    <= `BSROT_RST_SETPOINT;
            CH2_OFF_CODE    <= `BSROT_RST_SETPOINT;
            CH1_MAXOFF_CODE <= `BSROT_RST_SETPOINT;
            CH2_MAXOFF_CODE <= `BSROT_RST_SETPOINT;
        end else if (CLK_EN) begin
            CH2_PEAK_CODE   <= peak2_q;
            CH1_OFF_CODE    <= off_q[0];
            CH2_OFF_CODE    <= off_q[1];
            CH1_MAXOFF_CODE <= maxoff_q[0];
            CH2_MAXOFF_CODE <= maxoff_q[1];
        end
    end

    // ------------------------------------------------------------------------
    // comparator inputs from the analog side: three flops, then agreement
    // ------------------------------------------------------------------------
    // a glitch shorter than a clock never reaches the timers this way
    logic [3:0] async_in;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] filt_q;

    assign async_in = {CH_LOW_VLED, CH_TOFF_DONE};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge CORE_CLK or negedge RST_B) begin
            if (!RST_B) begin
                s1_q[i]   <= 1'b0;
                s2_q[i]   <= 1'b0;
                s3_q[i]   <= 1'b0;
                filt_q[i] <= 1'b0;
            end else if (CLK_EN) begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    filt_q[i] <= s3_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // per-channel maximum off-time timers
    // ------------------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_tmr
        bsrot_max_off_timer #(
            .LSB_CYC    (MAXOFF_LSB_CYC)
        ) u_tmr (
            .clk        (CORE_CLK),
            .rst_b      (RST_B),
            .ce         (CLK_EN),
            .max_code   (maxoff_q[c]),
            .off_start  (CH_OFF_START[c]),
            .toff_done  (filt_q[c]),
            .low_vled   (filt_q[c+2]),
            .off_end_q  (CH_OFF_END[c]),
            .max_hit_q  (CH_MAXOFF_HIT[c]),
            .start_ok_q (CH_START_OK[c])
        );
    end

    // ------------------------------------------------------------------------
    // thermal warning
    // ------------------------------------------------------------------------
    bsrot_thermal_warn u_warn (
        .clk        (CORE_CLK),
        .rst_b      (RST_B),
        .ce         (CLK_EN),
        .temp_code  (temp_q),
        .limit_code (warn_limit_q),
        .warn_clr   (WARN_CLR),
        .warn_q     (THERMAL_WARNING)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    peak_follow_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (CLK_EN && REG_WR && REG_ADDR == `BSROT_OFS_CH2_PEAK) ##1 CLK_EN
        |=> CH2_PEAK_CODE == $past(REG_WDATA[7:0], 2))
        else $error("peak threshold code did not follow the write");

    peak_budget_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (CLK_EN && REG_WR && REG_ADDR == `BSROT_OFS_CH2_PEAK) ##1 CLK_EN [*2]
        |-> ##[0:DAC_CYC] (CH2_PEAK_CODE == peak2_q))
        else $error("peak threshold dac code late");

    rsvd_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (REG_RVALID && is_setpoint(rd_addr_q)) |-> !REG_RDATA[`BSROT_RSVD_BIT])
        else $error("reserved setpoint bit read as one");

    off_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (CLK_EN && REG_RD && REG_ADDR == `BSROT_OFS_CH1_OFF)
        |=> (REG_RVALID && REG_RDATA == {1'b0, $past(off_q[0])}))
        else $error("channel 1 off-time read mismatch");

    maxoff_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        CLK_EN |=> CH2_MAXOFF_CODE == $past(maxoff_q[1]))
        else $error("channel 2 maximum off-time code stale");

    temp_cap_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (CLK_EN && TEMP_ADC_VALID) |=> temp_q == $past(TEMP_ADC_CODE))
        else $error("temperature reading not captured");

    temp_ro_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (!(CLK_EN && TEMP_ADC_VALID)) |=> $stable(temp_q))
        else $error("temperature register changed without a conversion");

    setpoint_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (CLK_EN && REG_WR && REG_ADDR == `BSROT_OFS_CH2_PEAK)
        |=> peak2_q == $past(REG_WDATA[7:0]))
        else $error("peak threshold write lost");

    start_ok_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        CH_START_OK[0] |=> CH_START_OK[0])
        else $error("channel 1 start permission withdrawn");

    maxoff1_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        CLK_EN |=> CH1_MAXOFF_CODE == $past(maxoff_q[0]))
        else $error("channel 1 maximum off-time code stale");
endmodule : bsrot_regs
`default_nettype wire

// *** hw/bsrot_consts.svh ***
// offsets, reset values, field positions and timing counts of the setpoint bank
// assumes a 200 MHz core clock; included by bare name from the hw folder
`ifndef BSROT_CONSTS_SVH
`define BSROT_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (register port word addresses)
// ----------------------------------------------------------------------------
`define BSROT_ADDR_W              5
`define BSROT_OFS_WARN_LIMIT      5'h02
`define BSROT_OFS_CH2_PEAK        5'h04
`define BSROT_OFS_CH1_OFF         5'h05
`define BSROT_OFS_CH2_OFF         5'h06
`define BSROT_OFS_CH1_MAXOFF      5'h07
`define BSROT_OFS_CH2_MAXOFF      5'h08
`define BSROT_OFS_DIE_TEMP        5'h09
`define BSROT_OFS_CH1_LATEST      5'h0A

// ----------------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------------
`define BSROT_CODE_MSB            7
`define BSROT_RSVD_BIT            8
`define BSROT_RST_SETPOINT        8'h80
`define BSROT_RST_WARN_LIMIT      8'h80
`define BSROT_RST_READING         8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BSROT_CLK_PERIOD_NS       5
`define BSROT_MAXOFF_LSB_NS       251
`define BSROT_MAXOFF_LSB_CYC      (`BSROT_MAXOFF_LSB_NS / `BSROT_CLK_PERIOD_NS)
`define BSROT_DAC_UPDATE_NS       1000
`define BSROT_DAC_UPDATE_CYC      (`BSROT_DAC_UPDATE_NS / `BSROT_CLK_PERIOD_NS)

`endif

// *** hw/bsrot_pkg.sv ***
// types shared by the setpoint bank and its timers
// assumes nothing beyond a SystemVerilog compiler
package bsrot_pkg;
    typedef logic [7:0] bsrot_code_type;

    // per-channel maximum off-time timer states
    typedef enum logic [1:0] {
        TMR_WAIT_POR,
        TMR_IDLE,
        TMR_OFF
    } bsrot_tmr_state_type;
endpackage : bsrot_pkg

// *** hw/bsrot_thermal_warn.sv ***
// latched thermal warning: die temperature code against the warning limit
// assumes temp and limit are registered on the same clock
`timescale 1ns/1ps
`default_nettype none
module bsrot_thermal_warn
    import bsrot_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           ce,
    // compare inputs
    input  wire bsrot_code_type temp_code,
    input  wire bsrot_code_type limit_code,
    // status read clear and flag
    input  wire logic           warn_clr,
    output var  logic           warn_q
);
    logic over;

    assign over = temp_code > limit_code;

    // set wins over clear, and a clear only takes once the condition is gone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_q <= 1'b0;
        end else if (ce) begin
            if (over) begin
                warn_q <= 1'b1;
            end else if (warn_clr) begin
                warn_q <= 1'b0;
            end
        end
    end

    warn_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && over) |=> warn_q)
        else $error("thermal warning not set on over-limit reading");

    warn_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (warn_q && !(ce && warn_clr)) |=> warn_q)
        else $error("thermal warning dropped without a clear");
endmodule : bsrot_thermal_warn
`default_nettype wire

// *** hw/bsrot_max_off_timer.sv ***
// one channel's maximum off-time timer, also the power-on start delay
// assumes toff_done and low_vled are already synchronised and filtered
`timescale 1ns/1ps
`default_nettype none
`include "bsrot_consts.svh"
module bsrot_max_off_timer
    import bsrot_pkg::*;
#(
    parameter int LSB_CYC = `BSROT_MAXOFF_LSB_CYC
)(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           ce,
    // setpoint
    input  wire bsrot_code_type max_code,
    // converter off interval
    input  wire logic           off_start,
    input  wire logic           toff_done,
    input  wire logic           low_vled,
    output var  logic           off_end_q,
    output var  logic           max_hit_q,
    output var  logic           start_ok_q
);
    localparam logic [15:0] PRE_LAST = 16'(LSB_CYC - 1);

    bsrot_tmr_state_type state_q;
    logic [15:0]         pre_q;
    bsrot_code_type      lsb_q;
    logic                expired;
    logic                toff_ok;
    logic                restart;
    logic                end_now;

    assign expired = lsb_q >= max_code;
    assign toff_ok = toff_done && !low_vled;
    assign restart = (state_q == TMR_IDLE) && off_start;
    assign end_now = (state_q == TMR_OFF) && (toff_ok || expired);

    // ------------------------------------------------------------------------
    // interval counter: one lsb per LSB_CYC cycles, 250 ns at 200 MHz, stops once expired
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 16'h0000;
            lsb_q <= 8'h00;
        end else if (ce) begin
            if (restart) begin
                pre_q <= 16'h0000;
                lsb_q <= 8'h00;
            end else if (!expired) begin
                if (pre_q == PRE_LAST) begin
                    pre_q <= 16'h0000;
                    lsb_q <= lsb_q + 8'h01;
                end else begin
                    pre_q <= pre_q + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // sequencing: first a full interval after reset, then per off interval
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= TMR_WAIT_POR;
            start_ok_q <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                TMR_WAIT_POR: begin
                    if (expired) begin
                        state_q    <= TMR_IDLE;
                        start_ok_q <= 1'b1;
                    end
                end
                TMR_IDLE: begin
                    if (off_start) begin
                        state_q <= TMR_OFF;
                    end
                end
                TMR_OFF: begin
                    if (end_now) begin
                        state_q <= TMR_IDLE;
                    end
                end
            endcase
        end
    end

    // end pulse; max_hit marks which timer ended it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            off_end_q <= 1'b0;
            max_hit_q <= 1'b0;
        end else if (ce) begin
            off_end_q <= end_now;
            max_hit_q <= end_now && expired && !toff_ok;
        end
    end

    // helper: cycles spent in an off interval, for the bound check
    logic [15:0] off_cyc_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            off_cyc_q <= 16'h0000;
        end else if (ce) begin
            off_cyc_q <= (state_q == TMR_OFF) ? off_cyc_q + 16'h0001 : 16'h0000;
        end
    end

    maxoff_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == TMR_OFF) |-> (32'(off_cyc_q) <= 32'(max_code) * LSB_CYC + 1))
        else $error("off interval outlived the maximum off-time");

    por_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        off_end_q |-> start_ok_q)
        else $error("off interval ended before the power-on wait");

    low_vled_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && state_q == TMR_OFF && low_vled && !expired) |=> !off_end_q)
        else $error("regular off timer ended interval at low led voltage");

    toff_par_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && state_q == TMR_OFF && toff_ok) |=> (off_end_q && !max_hit_q))
        else $error("regular off timer end not honoured");
endmodule : bsrot_max_off_timer
`default_nettype wire

// *** verification/bsrot_regs_bench.sv ***
// bench for the setpoint bank: register port, dac codes, warning, timers
// assumes the bank is built with a 2-cycle max off-time step
`timescale 1ns/1ps
`default_nettype none
module bsrot_regs_bench;
    import bsrot_pkg::*;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, tv = 0, vv = 0, pwm = 0, clr = 0;
    logic [4:0] addr = 0;
    logic [8:0] wdata = 0, rdata;
    logic [1:0] start = 0, done = 0, low = 0, oend, hit, sok;
    bsrot_code_type tcode = 0, vcode = 0, pk, o1, o2, m1, m2;
    logic rvalid, warn;
    int failures = 0, n_compared = 0, cyc = 0, n;
    logic [4:0] ra [9] = '{5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h1F};
    always #2.5 clk = ~clk;
    bsrot_regs #(.MAXOFF_LSB_CYC(2)) bsrot_regs_inst (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .TEMP_ADC_CODE(tcode), .TEMP_ADC_VALID(tv), .VLED1_ADC_CODE(vcode),
        .VLED1_ADC_PWM(pwm), .VLED1_ADC_VALID(vv), .WARN_CLR(clr), .CH_OFF_START(start),
        .CH_TOFF_DONE(done), .CH_LOW_VLED(low), .CH_OFF_END(oend), .CH_MAXOFF_HIT(hit),
        .CH_START_OK(sok), .CH2_PEAK_CODE(pk), .CH1_OFF_CODE(o1), .CH2_OFF_CODE(o2),
        .CH1_MAXOFF_CODE(m1), .CH2_MAXOFF_CODE(m2), .THERMAL_WARNING(warn));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [4:0] a, input logic [8:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask : wr_reg
    // strobe lowered on the answer edge, so reads never overlap
    task automatic rd_chk(input logic [4:0] a, input logic [8:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk({8'h00, rvalid}, 9'h001);
        chk(rdata, exp);
    endtask : rd_chk
    // one off interval on channel 1; n counts edges until its end pulse
    task automatic off_run(input logic lv, input logic [8:0] exp_hit);
        @(posedge clk);
        low <= {1'b0, lv};
        start <= 2'b01;
        done <= {1'b0, ~lv};
        @(posedge clk);
        start <= 2'b00;
        for (n = 1; n < 100; n++) begin
            @(posedge clk);
            #1;
            if (oend[0] === 1'b1) break;
        end
        chk({8'h00, hit[0]}, exp_hit);
        @(posedge clk);
        done <= 2'b00;
    endtask : off_run
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // hang guard: whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            give_verdict();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        repeat (200) @(posedge clk);
        #1 chk({7'h00, sok}, 9'h000);
        repeat (70) @(posedge clk);
        #1 chk({7'h00, sok}, 9'h003);
        for (int i = 0; i < 9; i++) rd_chk(ra[i], (i < 6) ? 9'h080 : 9'h000);
        for (int i = 0; i < 9; i++) wr_reg(ra[i], 9'h100 | (9'h011 * (i + 1)));
        for (int i = 0; i < 9; i++) rd_chk(ra[i], (i < 6) ? 9'h011 * (i + 1) : 9'h000);
        chk({1'b0, pk}, 9'h022);
        chk({1'b0, o1}, 9'h033);
        chk({1'b0, o2}, 9'h044);
        chk({1'b0, m1}, 9'h055);
        chk({1'b0, m2}, 9'h066);
        @(posedge clk);
        tcode <= 8'h12;
        tv <= 1;
        vcode <= 8'h3C;
        pwm <= 1;
        vv <= 1;
        @(posedge clk);
        tv <= 0;
        vv <= 0;
        repeat (2) @(posedge clk);
        #1 chk({8'h00, warn}, 9'h001);
        rd_chk(5'h09, 9'h012);
        rd_chk(5'h0A, 9'h13C);
        // clear while still over must lose; the next clear after a cool reading wins
        @(posedge clk);
        clr <= 1;
        tcode <= 8'h05;
        tv <= 1;
        @(posedge clk);
        tv <= 0;
        #1 chk({8'h00, warn}, 9'h001);
        @(posedge clk);
        clr <= 0;
        #1 chk({8'h00, warn}, 9'h000);
        wr_reg(5'h04, 9'h0FF);
        rd_chk(5'h04, 9'h0FF);
        chk({1'b0, pk}, 9'h0FF);
        wr_reg(5'h07, 9'h008);
        off_run(1'b1, 9'h001);
        chk({7'h00, n > 15 && n < 19}, 9'h001);
        off_run(1'b0, 9'h000);
        chk({7'h00, n < 12}, 9'h001);
        give_verdict();
    end
endmodule : bsrot_regs_bench
`default_nettype wire
